// >>> hdl/flash_ctl_params.svh
// register offsets, field positions, reset values and timing counts
// assumes inclusion by the flash control module only
`ifndef FLASH_CTL_PARAMS_SVH
`define FLASH_CTL_PARAMS_SVH
`define OFS_DATA_LOW 4'h0
`define OFS_DATA_HIGH 4'h1
`define OFS_ADDR_LOW 4'h2
`define OFS_ADDR_HIGH 4'h3
`define OFS_CONTROL 4'h4
`define OFS_UNLOCK 4'h5
`define OFS_INT_STATUS 4'h6
`define OFS_INT_MASK 4'h7
`define BIT_GO 0
`define BIT_LATCH_ONLY 1
`define BIT_ERASE 2
`define BIT_FAULT 3
`define BIT_WRITE_EN 4
`define UNLOCK_KEY1 8'h55
`define UNLOCK_KEY2 8'hAA
`define LATCH_ERASED 14'h3FFF
`define ROW_WORDS 32
`define OP_TIME_NS 2000
`define OP_CYCLES ((`OP_TIME_NS + 4) / 5)
`define PROTECT_LIMIT_RST 15'h0000
`endif

// >>> hdl/flash_ctl_pkg.sv
// types shared by the flash control block
// assumes flash_ctl_params.svh is available on the include path
package flash_ctl_pkg;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_ERASE = 4'b0010,
		ST_WRITE = 4'b0100,
		ST_DONE = 4'b1000
	} op_state_t;
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;
	typedef struct packed {
		logic req;
		logic erase;
		logic [14:0] addr;
		logic [13:0] data;
	} array_cmd_t;
endpackage

// >>> hdl/flash_ctl.sv
// self-programming control for program flash: registers, latches, protection
// assumes a flash array model that takes one erase/word-program per request
//
// Behaviour
// - erase or row-write go with address in protected region sets the fault flag
// - a warm reset during a self-write sets the fault flag; a power-on reset does not
// - interrupted unlock sequence sets the fault flag
// - fault flag set by hardware or software, cleared by software or a power-on reset
// - erase select with go erases the whole 32-word row, data ignored
// - protected erase or row write clears go, faults, no array change
// - latch-only go copies data word into latch, protection ignored
// - row write programs latches into row, then latches reset to ones
// - 14-bit data word, high register top two bits read zero
// - 15-bit address, high register top bit reads one
// - address high top bit may read either value during a write
`timescale 1ns/100ps
`include "flash_ctl_params.svh"
module flash_ctl (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// reset while busy: high when this reset came from a non-power source
	input wire logic warmReset,
	// register port
	input wire flash_ctl_pkg::reg_req_t regReq,
	output logic [7:0] regRdata,
	// protection boundary: addresses below it are protected
	input wire logic [14:0] protectLimit,
	// flash array command
	output flash_ctl_pkg::array_cmd_t arrayCmd,
	input wire logic arrayDone,
	// interrupt
	output logic irq
);
	////////////////////////////////////////////////////////////////////////
	logic [13:0] dataWord_ff, nxt_dataWord;
	logic [14:0] addrWord_ff, nxt_addrWord;
	logic go_ff, nxt_go, erase_ff, nxt_erase, latch_only_select_ff, nxt_latch_only_select;
	logic fault_ff, nxt_fault, wen_ff, nxt_wen;
	logic [1:0] unlock_ff, nxt_unlock;
	logic [1:0] intStat_ff, nxt_intStat, intMask_ff, nxt_intMask;
	logic [7:0] regRdata_ff, nxt_regRdata;
	logic [13:0] latch_ff [`ROW_WORDS];
	logic [13:0] nxt_latch [`ROW_WORDS];
	flash_ctl_pkg::op_state_t state_ff, nxt_state;
	logic [4:0] idx_ff, nxt_idx;
	logic [8:0] wait_ff, nxt_wait;
	flash_ctl_pkg::array_cmd_t cmd_ff, nxt_cmd;
	logic busyMark_ff, nxt_busyMark;
	logic protHit, goStart, opEnd;

	function automatic logic isProtected(input logic [14:0] a,
		input logic [14:0] lim);
		isProtected = a < lim;
	endfunction

	assign protHit = isProtected(addrWord_ff, protectLimit);
	assign goStart = regReq.wr && regReq.addr == `OFS_CONTROL &&
		regReq.wdata[`BIT_GO] && !go_ff && wen_ff && unlock_ff == 2'd2;

	////////////////////////////////////////////////////////////////////////
	// registers and operation sequencer
	always_comb begin
		nxt_dataWord = dataWord_ff;
		nxt_addrWord = addrWord_ff;
		nxt_go = go_ff;
		nxt_erase = erase_ff;
		nxt_latch_only_select = latch_only_select_ff;
		nxt_fault = fault_ff;
		nxt_wen = wen_ff;
		nxt_unlock = unlock_ff;
		nxt_intStat = intStat_ff;
		nxt_intMask = intMask_ff;
		nxt_state = state_ff;
		nxt_idx = idx_ff;
		nxt_wait = wait_ff;
		nxt_cmd = cmd_ff;
		nxt_cmd.req = 1'b0;
		nxt_busyMark = busyMark_ff;
		opEnd = 1'b0;
		for (int i = 0; i < `ROW_WORDS; i++) begin
			nxt_latch[i] = latch_ff[i];
		end
		nxt_regRdata = 8'h00;
		if (regReq.rd) begin
			unique case (regReq.addr)
				`OFS_DATA_LOW: nxt_regRdata = dataWord_ff[7:0];
				`OFS_DATA_HIGH: nxt_regRdata = {2'b00, dataWord_ff[13:8]};
				`OFS_ADDR_LOW: nxt_regRdata = addrWord_ff[7:0];
				// top bit reads one; not promised while a write runs
				`OFS_ADDR_HIGH: nxt_regRdata = {1'b1, addrWord_ff[14:8]};
				`OFS_CONTROL: nxt_regRdata = {3'b000, wen_ff, fault_ff,
					erase_ff, latch_only_select_ff, go_ff};
				`OFS_INT_STATUS: nxt_regRdata = {6'h00, intStat_ff};
				`OFS_INT_MASK: nxt_regRdata = {6'h00, intMask_ff};
				default: nxt_regRdata = 8'h00;
			endcase
		end
		if (regReq.wr) begin
			unique case (regReq.addr)
				`OFS_DATA_LOW: nxt_dataWord[7:0] = regReq.wdata;
				`OFS_DATA_HIGH: nxt_dataWord[13:8] = regReq.wdata[5:0];
				`OFS_ADDR_LOW: if (!go_ff) nxt_addrWord[7:0] = regReq.wdata;
				`OFS_ADDR_HIGH: if (!go_ff) nxt_addrWord[14:8] = regReq.wdata[6:0];
				`OFS_UNLOCK: begin
					if (unlock_ff == 2'd0 && regReq.wdata == `UNLOCK_KEY1) begin
						nxt_unlock = 2'd1;
					end else if (unlock_ff == 2'd1 &&
						regReq.wdata == `UNLOCK_KEY2) begin
						nxt_unlock = 2'd2;
					end else begin
						nxt_unlock = 2'd0;
						nxt_fault = fault_ff || unlock_ff != 2'd0;
					end
				end
				`OFS_CONTROL: begin
					nxt_unlock = 2'd0;
					if (!go_ff) begin
						nxt_erase = regReq.wdata[`BIT_ERASE];
						nxt_latch_only_select = regReq.wdata[`BIT_LATCH_ONLY];
						nxt_wen = regReq.wdata[`BIT_WRITE_EN];
					end
					// software may set the flag for test, or clear it
					nxt_fault = regReq.wdata[`BIT_FAULT];
				end
				`OFS_INT_STATUS: nxt_intStat = intStat_ff & ~regReq.wdata[1:0];
				`OFS_INT_MASK: nxt_intMask = regReq.wdata[1:0];
				default: ;
			endcase
			// after the case, so a control write cannot wipe the break fault
			if (regReq.addr != `OFS_UNLOCK && unlock_ff != 2'd0 &&
				!(regReq.addr == `OFS_CONTROL && unlock_ff == 2'd2)) begin
				nxt_unlock = 2'd0;
				nxt_fault = 1'b1;
			end
		end
		unique case (state_ff)
			flash_ctl_pkg::ST_IDLE: begin
				if (goStart) begin
					nxt_go = 1'b1;
					nxt_wait = 9'd0;
					nxt_idx = 5'd0;
					if (!erase_ff && latch_only_select_ff) begin
						// latch load: protection ignored, no array access
						nxt_latch[addrWord_ff[4:0]] = dataWord_ff;
						nxt_state = flash_ctl_pkg::ST_DONE;
					end else if (protHit) begin
						nxt_fault = 1'b1;
						nxt_go = 1'b0;
					end else if (erase_ff) begin
						nxt_busyMark = 1'b1;
						nxt_cmd = '{req: 1'b1, erase: 1'b1,
							addr: {addrWord_ff[14:5], 5'd0}, data: 14'h0000};
						nxt_state = flash_ctl_pkg::ST_ERASE;
					end else begin
						nxt_busyMark = 1'b1;
						nxt_state = flash_ctl_pkg::ST_WRITE;
						nxt_cmd = '{req: 1'b1, erase: 1'b0,
							addr: {addrWord_ff[14:5], 5'd0}, data: latch_ff[0]};
					end
				end
			end
			flash_ctl_pkg::ST_ERASE: begin
				nxt_wait = wait_ff + 9'd1;
				if (arrayDone || wait_ff == 9'(`OP_CYCLES)) begin
					nxt_state = flash_ctl_pkg::ST_DONE;
				end
			end
			flash_ctl_pkg::ST_WRITE: begin
				if (arrayDone) begin
					if (idx_ff == 5'(`ROW_WORDS - 1)) begin
						for (int i = 0; i < `ROW_WORDS; i++) begin
							nxt_latch[i] = `LATCH_ERASED;
						end
						nxt_state = flash_ctl_pkg::ST_DONE;
					end else begin
						nxt_idx = idx_ff + 5'd1;
						nxt_cmd.req = 1'b1;
						nxt_cmd.addr = {addrWord_ff[14:5], idx_ff + 5'd1};
						nxt_cmd.data = latch_ff[idx_ff + 5'd1];
					end
				end
			end
			flash_ctl_pkg::ST_DONE: begin
				opEnd = 1'b1;
				nxt_go = 1'b0;
				nxt_busyMark = 1'b0;
				nxt_state = flash_ctl_pkg::ST_IDLE;
			end
		endcase
		// set wins over a clear in the same cycle
		if (opEnd) nxt_intStat[0] = 1'b1;
		if (nxt_fault && !fault_ff) nxt_intStat[1] = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dataWord_ff <= 14'h0000;
			addrWord_ff <= 15'h0000;
			go_ff <= 1'b0;
			erase_ff <= 1'b0;
			latch_only_select_ff <= 1'b0;
			wen_ff <= 1'b0;
			unlock_ff <= 2'd0;
			intStat_ff <= 2'b00;
			intMask_ff <= 2'b00;
			regRdata_ff <= 8'h00;
			state_ff <= flash_ctl_pkg::ST_IDLE;
			idx_ff <= 5'd0;
			wait_ff <= 9'd0;
			cmd_ff <= '0;
			for (int i = 0; i < `ROW_WORDS; i++) begin
				latch_ff[i] <= `LATCH_ERASED;
			end
		end else begin
			dataWord_ff <= nxt_dataWord;
			addrWord_ff <= nxt_addrWord;
			go_ff <= nxt_go;
			erase_ff <= nxt_erase;
			latch_only_select_ff <= nxt_latch_only_select;
			wen_ff <= nxt_wen;
			unlock_ff <= nxt_unlock;
			intStat_ff <= nxt_intStat;
			intMask_ff <= nxt_intMask;
			regRdata_ff <= nxt_regRdata;
			state_ff <= nxt_state;
			idx_ff <= nxt_idx;
			wait_ff <= nxt_wait;
			cmd_ff <= nxt_cmd;
			latch_ff <= nxt_latch;
		end
	end

	// the fault flag and busy marker hold through warm resets, so a reset
	// landing mid-write leaves a trace; a power-on reset clears the flag, and every reset release clears the marker
	logic warmSync1_ff, warmSync2_ff;
	// free-running, so it still follows warmReset while nrst holds the rest
	always_ff @(posedge clk) begin
		warmSync1_ff <= warmReset;
		warmSync2_ff <= warmSync1_ff;
	end
	logic porSeen_ff;
	always_ff @(posedge clk) begin
		porSeen_ff <= nrst;
		if (!porSeen_ff && nrst) begin
			// first edge after release: a warm reset with busy marked faults
			fault_ff <= warmSync2_ff ? (fault_ff | busyMark_ff) : 1'b0;
			busyMark_ff <= 1'b0;
		end else if (nrst) begin
			fault_ff <= nxt_fault;
			busyMark_ff <= nxt_busyMark;
		end
	end

	assign regRdata = regRdata_ff;
	assign arrayCmd = cmd_ff;
	assign irq = |(intStat_ff & intMask_ff);

	////////////////////////////////////////////////////////////////////////
	chk_prot_fault: assert property (@(posedge clk)
		disable iff (!nrst) goStart && !latch_only_select_ff && protHit
		|=> fault_ff && !go_ff)
		else $error("protected go did not fault");
	chk_prot_noop: assert property (@(posedge clk)
		disable iff (!nrst) goStart && !(latch_only_select_ff && !erase_ff) && protHit
		|=> !arrayCmd.req)
		else $error("protected go touched the array");
	chk_fault_sticky: assert property (@(posedge clk)
		disable iff (!nrst)
		fault_ff && !(regReq.wr && regReq.addr == `OFS_CONTROL)
		|=> fault_ff)
		else $error("fault flag cleared by hardware");
	chk_erase_row: assert property (@(posedge clk)
		disable iff (!nrst) goStart && erase_ff && !protHit
		|=> arrayCmd.req && arrayCmd.erase && arrayCmd.addr[4:0] == 5'd0)
		else $error("row erase not issued");
	chk_latch_load: assert property (@(posedge clk)
		disable iff (!nrst) goStart && latch_only_select_ff && !erase_ff
		|=> latch_ff[$past(addrWord_ff[4:0])] == $past(dataWord_ff)
		&& !arrayCmd.req)
		else $error("latch load wrong");
	chk_row_next: assert property (@(posedge clk)
		disable iff (!nrst)
		state_ff == flash_ctl_pkg::ST_WRITE && arrayDone
		&& idx_ff != 5'(`ROW_WORDS - 1)
		|=> arrayCmd.req && !arrayCmd.erase)
		else $error("next row word not issued");
	chk_latch_reset: assert property (@(posedge clk)
		disable iff (!nrst)
		state_ff == flash_ctl_pkg::ST_WRITE && arrayDone
		&& idx_ff == 5'(`ROW_WORDS - 1)
		|=> latch_ff[0] == `LATCH_ERASED
		&& latch_ff[`ROW_WORDS - 1] == `LATCH_ERASED)
		else $error("latches not reset after row write");
	chk_go_clear: assert property (@(posedge clk)
		disable iff (!nrst) state_ff == flash_ctl_pkg::ST_DONE
		|=> !go_ff)
		else $error("go not cleared at end");
	chk_data_high: assert property (@(posedge clk)
		disable iff (!nrst) regReq.rd && regReq.addr == `OFS_DATA_HIGH
		|=> regRdata[7:6] == 2'b00)
		else $error("data high top bits not zero");
	chk_addr_high: assert property (@(posedge clk)
		disable iff (!nrst) regReq.rd && regReq.addr == `OFS_ADDR_HIGH
		|=> regRdata[7])
		else $error("address high top bit not one");
	chk_unlock_break: assert property (@(posedge clk)
		disable iff (!nrst) regReq.wr && regReq.addr == `OFS_UNLOCK
		&& unlock_ff == 2'd1 && regReq.wdata != `UNLOCK_KEY2
		|=> fault_ff)
		else $error("broken unlock did not fault");
	chk_unlock_ctrl: assert property (@(posedge clk)
		disable iff (!nrst) regReq.wr && regReq.addr == `OFS_CONTROL
		&& unlock_ff == 2'd1
		|=> fault_ff)
		else $error("unlock cut by a control write did not fault");
endmodule

// >>> tb/flash_ctl_test.sv
// self-checking bench for the flash self-programming control block
// assumes flash_ctl_pkg is compiled first and flash_ctl_params.svh is on path
`timescale 1ns/100ps
`define CHK(a, b) begin checksDone++; if ((a) !== (b)) begin \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); \
	numErrors++; end end
module flash_ctl_test;
	logic clk;
	logic nrst;
	logic warmReset;
	logic arrayDone;
	logic autoAns;
	logic irq;
	logic [7:0] regRdata;
	logic [7:0] rv;
	logic [14:0] protectLimit;
	logic [14:0] lastAddr;
	logic [2:0] dly;
	logic [13:0] words [32];
	flash_ctl_pkg::reg_req_t regReq;
	flash_ctl_pkg::array_cmd_t arrayCmd;
	int reqCount;
	int eraseCount;
	int r0;
	int numErrors;
	int checksDone;

	flash_ctl dut (
		.clk(clk),
		.nrst(nrst),
		.warmReset(warmReset),
		.regReq(regReq),
		.regRdata(regRdata),
		.protectLimit(protectLimit),
		.arrayCmd(arrayCmd),
		.arrayDone(arrayDone),
		.irq(irq)
	);

	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// array stand-in: answers each request four cycles later unless held off
	always @(posedge clk) begin
		dly <= {dly[1:0], arrayCmd.req & autoAns};
		arrayDone <= dly[2];
		if (arrayCmd.req === 1'b1) begin
			reqCount++;
			if (arrayCmd.erase)
				eraseCount++;
			words[arrayCmd.addr[4:0]] = arrayCmd.data;
			lastAddr = arrayCmd.addr;
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		regReq.wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		regReq.rd <= 1'b0;
		#1 rv = regRdata;
	endtask

	// mode and enable bits are taken from the register, so set them first
	task automatic unlockGo(input logic [7:0] ctrl);
		wr(4'h4, ctrl & 8'hFE);
		wr(4'h5, 8'h55);
		wr(4'h5, 8'hAA);
		wr(4'h4, ctrl);
	endtask

	// polls go with a bound; a stuck go shows up in the following checks
	task automatic go(input logic [7:0] ctrl);
		unlockGo(ctrl);
		for (int i = 0; i < 400; i++) begin
			rd(4'h4);
			if (rv[0] === 1'b0)
				break;
		end
	endtask

	task automatic conclude;
		$display("checks %0d mismatches %0d", checksDone, numErrors);
		if (numErrors == 0 && checksDone > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		nrst = 1'b0;
		warmReset = 1'b0;
		arrayDone = 1'b0;
		autoAns = 1'b1;
		dly = 3'b000;
		regReq = '0;
		protectLimit = 15'h4000;
		reqCount = 0;
		eraseCount = 0;
		numErrors = 0;
		checksDone = 0;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
		rd(4'h4); `CHK(rv, 8'h00)
		rd(4'h3); `CHK(rv, 8'h80)
		wr(4'h1, 8'hFF); rd(4'h1); `CHK(rv, 8'h3F)
		wr(4'h3, 8'hFF); rd(4'h3); `CHK(rv, 8'hFF)
		$display("register layout test done");
		// word 0x0123: row 9, latch 3
		wr(4'h2, 8'h23); wr(4'h3, 8'h01);
		wr(4'h0, 8'h5C); wr(4'h1, 8'h2A);
		wr(4'h7, 8'h00);
		go(8'h13);
		`CHK({rv[3], rv[0]}, 2'b00)
		`CHK(reqCount, 0)
		rd(4'h6); `CHK(rv[0], 1'b1)
		`CHK(irq, 1'b0)
		wr(4'h7, 8'h01); #1 `CHK(irq, 1'b1)
		wr(4'h6, 8'h01); #1 `CHK(irq, 1'b0)
		$display("latch load test done");
		wr(4'h7, 8'h02);
		for (int i = 0; i < 2; i++) begin
			go(i == 0 ? 8'h15 : 8'h11);
			`CHK({rv[3], rv[0]}, 2'b10)
			`CHK(reqCount, 0)
			#1 `CHK(irq, 1'b1)
			wr(4'h6, 8'h03); wr(4'h4, 8'h00);
		end
		$display("protection test done");
		rd(4'h4); `CHK(rv[3], 1'b0)
		wr(4'h4, 8'h08); rd(4'h4); rd(4'h4); `CHK(rv[3], 1'b1)
		wr(4'h4, 8'h00);
		wr(4'h5, 8'h55); wr(4'h0, 8'h5C);
		rd(4'h4); `CHK(rv[3], 1'b1)
		wr(4'h4, 8'h00);
		wr(4'h5, 8'h55);
		wr(4'h4, 8'h00);
		rd(4'h4); `CHK(rv[3], 1'b1)
		wr(4'h4, 8'h00);
		$display("fault flag test done");
		protectLimit <= 15'h0000;
		go(8'h15);
		`CHK({rv[3], rv[0]}, 2'b00)
		`CHK(eraseCount, 1)
		`CHK(lastAddr[14:5], 10'h009)
		r0 = reqCount;
		go(8'h11);
		`CHK(reqCount - r0, 32)
		`CHK(words[3], 14'h2A5C)
		`CHK(words[4], 14'h3FFF)
		`CHK(lastAddr[14:5], 10'h009)
		go(8'h11);
		`CHK(words[3], 14'h3FFF)
		`CHK(eraseCount, 1)
		$display("erase and row write test done");
		// no answer from the array so the erase is still running at reset
		autoAns <= 1'b0;
		unlockGo(8'h15);
		warmReset <= 1'b1;
		repeat (4) @(posedge clk);
		nrst <= 1'b0;
		repeat (3) @(posedge clk);
		`CHK(irq, 1'b0)
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
		rd(4'h4); `CHK(rv[3], 1'b1)
		$display("reset during write test done");
		conclude();
	end

	initial begin
		#(20000 * 5);
		numErrors++;
		conclude();
	end
endmodule
